// >>> hdl/srtc_pkg.sv
// srtc_pkg: register map, field layout and reset values of the range and
// time constant 1 configuration registers.
// assumes an 8-bit register address space and 8-bit data.
package srtc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] RANGE_ADDR = 8'h01;
  localparam logic [7:0] RANGE_RST  = 8'h07;
  localparam logic [7:0] TC1_ADDR   = 8'h02;
  localparam logic [7:0] TC1_RST    = 8'h90;
  localparam int unsigned DRV_DIS_BIT = 7;
  localparam int unsigned UPPER_HI    = 6;
  localparam int unsigned UPPER_LO    = 4;
  localparam int unsigned RANGE_RSV   = 3;
  localparam int unsigned LOWER_HI    = 2;
  localparam int unsigned LOWER_LO    = 0;
  localparam int unsigned CAP_HI      = 7;
  localparam int unsigned CAP_LO      = 6;
  localparam int unsigned TC1_RSV     = 5;
  localparam int unsigned RES_HI      = 4;
  localparam int unsigned RES_LO      = 0;
  localparam logic [2:0] DRIVE_OFF_CODE = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// >>> hdl/srtc_reg8.sv
// srtc_reg8: one 8-bit read/write register with a reset value.
// assumes write strobe is synchronous to core_clk.
`timescale 1ns/1ps
module srtc_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (wr_en)
      q_nxt = wr_data;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q_r <= RST_VAL;
    else if (clk_en)
      q_r <= q_nxt;
  end

  assign q = q_r;
endmodule

// >>> hdl/srtc_regs.sv
// srtc_regs: range and time constant 1 configuration registers.
// assumes a host port engine on core_clk supplying address, write strobe
// and data; reads return registered data one cycle after rd_en.
`timescale 1ns/1ps
module srtc_regs
  import srtc_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic [srtc_pkg::ADDR_W-1:0] addr,
  input  wire logic                        wr_en,
  input  wire logic [srtc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        rd_en,
  output logic      [srtc_pkg::DATA_W-1:0] rd_data,
  output logic                             upper_drive_disable,
  output logic      [2:0]                  upper_resistance_range,
  output logic      [2:0]                  upper_drive_code,
  output logic                             upper_drive_on,
  output logic      [2:0]                  lower_resistance_range,
  output logic      [1:0]                  time_const1_capacitance,
  output logic      [4:0]                  time_const1_resistance
);
  import srtc_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic [7:0] range_q;
  logic [7:0] tc1_q;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic       drv_dis_r;
  logic       drv_dis_nxt;
  logic [2:0] upper_r;
  logic [2:0] upper_nxt;
  logic [2:0] drv_code_r;
  logic [2:0] drv_code_nxt;
  logic       drv_on_r;
  logic       drv_on_nxt;
  logic [2:0] lower_r;
  logic [2:0] lower_nxt;
  logic [1:0] cap_r;
  logic [1:0] cap_nxt;
  logic [4:0] res_r;
  logic [4:0] res_nxt;

  // reserved bits are kept as written so readback matches the host
  srtc_reg8 #(.RST_VAL(RANGE_RST)) u_range (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .wr_en    (wr_en && hit(addr, RANGE_ADDR)),
    .wr_data  (wr_data),
    .q        (range_q)
  );

  srtc_reg8 #(.RST_VAL(TC1_RST)) u_tc1 (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .wr_en    (wr_en && hit(addr, TC1_ADDR)),
    .wr_data  (wr_data),
    .q        (tc1_q)
  );

  always_comb
  begin
    rd_nxt = rd_r;
    if (rd_en)
    begin
      if (hit(addr, RANGE_ADDR))
        rd_nxt = range_q;
      else if (hit(addr, TC1_ADDR))
        rd_nxt = tc1_q;
      else
        rd_nxt = READ_ZERO;
    end
    drv_dis_nxt = range_q[DRV_DIS_BIT];
    upper_nxt   = range_q[UPPER_HI:UPPER_LO];
    lower_nxt   = range_q[LOWER_HI:LOWER_LO];
    // drive off overrides the programmed code; code held at a safe value
    drv_on_nxt   = !range_q[DRV_DIS_BIT];
    drv_code_nxt = range_q[DRV_DIS_BIT] ? DRIVE_OFF_CODE
                                        : range_q[UPPER_HI:UPPER_LO];
    cap_nxt = tc1_q[CAP_HI:CAP_LO];
    res_nxt = tc1_q[RES_HI:RES_LO];
  end

  // derived outputs lag the storage register by one cycle, so every
  // output leaves a flip-flop; reset values match the register resets
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_r       <= READ_ZERO;
      drv_dis_r  <= RANGE_RST[DRV_DIS_BIT];
      upper_r    <= RANGE_RST[UPPER_HI:UPPER_LO];
      lower_r    <= RANGE_RST[LOWER_HI:LOWER_LO];
      drv_on_r   <= !RANGE_RST[DRV_DIS_BIT];
      drv_code_r <= RANGE_RST[UPPER_HI:UPPER_LO];
      cap_r      <= TC1_RST[CAP_HI:CAP_LO];
      res_r      <= TC1_RST[RES_HI:RES_LO];
    end
    else if (clk_en)
    begin
      rd_r       <= rd_nxt;
      drv_dis_r  <= drv_dis_nxt;
      upper_r    <= upper_nxt;
      lower_r    <= lower_nxt;
      drv_on_r   <= drv_on_nxt;
      drv_code_r <= drv_code_nxt;
      cap_r      <= cap_nxt;
      res_r      <= res_nxt;
    end
  end

  assign rd_data                 = rd_r;
  assign upper_drive_disable     = drv_dis_r;
  assign upper_resistance_range  = upper_r;
  assign upper_drive_code        = drv_code_r;
  assign upper_drive_on          = drv_on_r;
  assign lower_resistance_range  = lower_r;
  assign time_const1_capacitance = cap_r;
  assign time_const1_resistance  = res_r;

  sequence s_wr_range;
    clk_en && wr_en && addr == RANGE_ADDR;
  endsequence

  sequence s_wr_tc1;
    clk_en && wr_en && addr == TC1_ADDR;
  endsequence

  a_range_readback: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_range ##1 (clk_en && rd_en && addr == RANGE_ADDR && !wr_en)
    |=> rd_data == $past(wr_data, 2))
    else $error("range register readback mismatch");

  a_tc1_readback: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_tc1 ##1 (clk_en && rd_en && addr == TC1_ADDR && !wr_en)
    |=> rd_data == $past(wr_data, 2))
    else $error("tc1 register readback mismatch");

  a_drive_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_range ##1 clk_en[*1] ##0 !wr_en
    |=> upper_drive_on == !$past(wr_data[DRV_DIS_BIT], 2)
        && (upper_drive_on || upper_drive_code == DRIVE_OFF_CODE))
    else $error("upper drive not gated by disable bit");

  a_upper_field: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_range ##1 (clk_en && !wr_en)
    |=> upper_resistance_range == $past(wr_data[UPPER_HI:UPPER_LO], 2))
    else $error("upper range field wrong");

  a_lower_field: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_range ##1 (clk_en && !wr_en)
    |=> lower_resistance_range == $past(wr_data[LOWER_HI:LOWER_LO], 2))
    else $error("lower range field wrong");

  a_cap_field: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_tc1 ##1 (clk_en && !wr_en)
    |=> time_const1_capacitance == $past(wr_data[CAP_HI:CAP_LO], 2))
    else $error("capacitance field wrong");

  a_res_field: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_tc1 ##1 (clk_en && !wr_en)
    |=> time_const1_resistance == $past(wr_data[RES_HI:RES_LO], 2))
    else $error("resistance field wrong");

  a_reserved_kept: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_wr_tc1 ##1 (clk_en && rd_en && addr == TC1_ADDR && !wr_en)
    |=> rd_data[TC1_RSV] == $past(wr_data[TC1_RSV], 2))
    else $error("reserved bit not stored");

  a_unmapped_zero: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && rd_en && addr != RANGE_ADDR && addr != TC1_ADDR
    |=> rd_data == READ_ZERO)
    else $error("unmapped read not zero");
endmodule

// >>> testbench/srtc_regs_test.sv
// srtc_regs_test: self-checking bench for the range and time constant 1
// configuration registers.
// assumes the plain strobe host port of srtc_regs on one 250 MHz clock.
`timescale 1ns/1ps
module srtc_regs_test;
  import srtc_pkg::*;
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        clk_en    = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic        wr_en     = 1'b0;
  logic [7:0]  wr_data   = 8'h00;
  logic        rd_en     = 1'b0;
  logic [7:0]  rd_data;
  logic        dis;
  logic        on;
  logic [2:0]  upr;
  logic [2:0]  code;
  logic [2:0]  lwr;
  logic [1:0]  cap;
  logic [4:0]  res;
  logic [7:0]  rng_m;
  logic [7:0]  tc_m;
  logic [25:0] notes[$];
  logic [25:0] nt;
  logic        tk        = 1'b0;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          i;

  srtc_regs dut (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .clk_en                 (clk_en),
    .addr                   (addr),
    .wr_en                  (wr_en),
    .wr_data                (wr_data),
    .rd_en                  (rd_en),
    .rd_data                (rd_data),
    .upper_drive_disable    (dis),
    .upper_resistance_range (upr),
    .upper_drive_code       (code),
    .upper_drive_on         (on),
    .lower_resistance_range (lwr),
    .time_const1_capacitance(cap),
    .time_const1_resistance (res)
  );

  always #2 core_clk = ~core_clk;

  // field outputs expected from the shadow copies
  function automatic logic [17:0] fexp();
    return {rng_m[7], rng_m[6:4], rng_m[7] ? DRIVE_OFF_CODE : rng_m[6:4],
            ~rng_m[7], rng_m[2:0], tc_m[7:6], tc_m[4:0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    // returns right after the taken edge so a read can follow back to back;
    // calling it twice in a row is safe, the later assignment of the strobe wins
    wr_en <= 1'b0;
    if (clk_en && a == RANGE_ADDR) rng_m = d;
    if (clk_en && a == TC1_ADDR) tc_m = d;
  endtask

  task automatic rd(input logic [7:0] a);
    notes.push_back({a == RANGE_ADDR ? rng_m : a == TC1_ADDR ? tc_m : 8'h00,
                     fexp()});
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rst(input int n);
    sys_rst <= 1'b1;
    rng_m = RANGE_RST;
    tc_m = TC1_RST;
    repeat (n) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // answer lands one edge after the read is taken; fields are checked too
  always @(posedge core_clk)
  begin
    if (tk)
    begin
      nt = notes.pop_front();
      n_tests++;
      if ({rd_data, dis, upr, code, on, lwr, cap, res} !== nt)
      begin
        error_cnt++;
        $display("unexpected read data and fields: expected %h seen %h",
                 nt, {rd_data, dis, upr, code, on, lwr, cap, res});
      end
    end
    tk = rd_en & clk_en & ~sys_rst;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'h35b5df4a));
    rst(20);
    rd(RANGE_ADDR);
    rd(TC1_ADDR);
    // lower code kept at or above upper code, so lower resistance never
    // exceeds upper resistance; drive disable set on half the passes as a
    // high-Q sensor would want; reserved bits always written as zero
    for (i = 0; i < 16; i++)
    begin
      wr(RANGE_ADDR,
         {i[3], i[2:0], 1'b0, i[2:0] | 3'($urandom)});
      rd(RANGE_ADDR);
      wr(TC1_ADDR, {i[1:0], 1'b0, 5'($urandom)});
      rd(TC1_ADDR);
    end
    wr(RANGE_ADDR, 8'hF7);
    rd(RANGE_ADDR);
    wr(8'h03, 8'h5A);
    rd(8'h03);
    rd(8'h00);
    rd(8'hFF);
    rd(TC1_ADDR);
    clk_en <= 1'b0;
    @(posedge core_clk);
    wr(TC1_ADDR, 8'h3C);
    clk_en <= 1'b1;
    @(posedge core_clk);
    rd(TC1_ADDR);
    rst(2);
    rd(RANGE_ADDR);
    rd(TC1_ADDR);
    repeat (2) @(posedge core_clk);
    close_out();
  end
endmodule
